// ---- rtl/mvs_media_id_valid_strap.sv ----
`timescale 1ns/100ps
// Functional notes
// (RULE1) sample both straps in reset, drive bit5
// (RULE2) drive0 strap low: bit5 reads 0
// (RULE3) drive0 strap high: bit5 reads 1
// (RULE4) drive1 strap maps the same for drive1
// (RULE5) drive0 strap loads function control bit0
// (RULE6) function control bit0 set voids strap meaning
// (RULE7) latched straps stay fixed until next reset
module mvs_media_id_valid_strap (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   media_valid_strap_drive0,
  input  wire logic                   media_valid_strap_drive1,
  input  wire logic [1:0]             mediaIdDrive0,
  input  wire logic [1:0]             mediaIdDrive1,
  input  wire logic [11:0]            regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic [7:0]                  regRdata,
  output logic                        data_rate_select,
  output logic                        strapsLoaded
);
  import mvs_pkg::*;

  // whole block state
  typedef struct packed {
    logic [7:0] rdata;      // read data, valid one cycle after strobe
    logic       fcrBit0;    // function control bit 0
    logic       fcrLoaded;  // strap copy into bit0 done once
    logic       driveSel;   // currently accessed drive
    logic       loaded;     // straps frozen
  } mvs_top_state_type;

  mvs_top_state_type state_reg;
  mvs_top_state_type state_next;
  mvs_req_type       req;          // bundled register request
  mvs_strap_type     strapPins;    // raw strap pins
  mvs_strap_type     strapLatched; // frozen strap values
  logic              sampleDone;   // sampler finished

  assign req       = '{addr: regAddr, wdata: regWdata,
                       wr: regWr, rd: regRd};
  assign strapPins = '{drive1: media_valid_strap_drive1,
                       drive0: media_valid_strap_drive0};

  // strap capture, pins synchronised inside
  mvs_strap_sampler sampler (
    .clk          (clk),
    .reset_n      (reset_n),
    .strapPins    (strapPins),
    .sampleDone   (sampleDone),
    .strapLatched (strapLatched)
  );

  // media id drive register image for the selected drive
  function automatic logic [7:0] media_reg_image(
    input logic       sel,
    input logic       rateMode,
    input mvs_strap_type straps,
    input logic [1:0] id0,
    input logic [1:0] id1
  );
    logic [7:0] img;
    img = REG_RESET;
    if (sel) begin
      img[MEDIA_VALID_BIT] = straps.drive1;                   // RULE4
      img[MEDIA_ID_LO_BIT +: 2] = id1;
    end else begin
      img[MEDIA_VALID_BIT] = straps.drive0;                   // RULE2 RULE3
      img[MEDIA_ID_LO_BIT +: 2] = id0;
    end
    // in data rate mode the strap carries no media meaning
    if (rateMode) begin
      img[MEDIA_VALID_BIT] = 1'b1;                            // RULE6
      img[MEDIA_ID_LO_BIT +: 2] = MEDIA_ID_RESET;
    end
    return img;
  endfunction

  // register decode and strap load
  always_comb begin
    state_next        = state_reg;
    state_next.rdata  = REG_RESET;
    state_next.loaded = sampleDone;
    // one-time copy once sampler freezes; before that bit follows strap
    if (!state_reg.fcrLoaded) begin
      state_next.fcrBit0 = strapLatched.drive0;                // RULE5
      state_next.fcrLoaded = sampleDone;
    end
    if (req.wr) begin
      unique case (req.addr)
        FUNC_CTRL_REG_ADDR: begin
          // software write wins only after the strap copy is in
          if (state_reg.fcrLoaded) begin
            state_next.fcrBit0 = req.wdata[DATA_RATE_SEL_BIT];
          end
        end
        DRIVE_SEL_REG_ADDR: begin
          state_next.driveSel = req.wdata[DRIVE_SEL_BIT];
        end
        default: begin
          // unmapped or read-only: write dropped
        end
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        MEDIA_ID_DRIVE_REG_ADDR: begin
          state_next.rdata = media_reg_image(state_reg.driveSel,
            state_reg.fcrBit0, strapLatched,
            mediaIdDrive0, mediaIdDrive1);                     // RULE1
        end
        FUNC_CTRL_REG_ADDR: begin
          state_next.rdata[DATA_RATE_SEL_BIT] = state_reg.fcrBit0;
        end
        DRIVE_SEL_REG_ADDR: begin
          state_next.rdata[DRIVE_SEL_BIT] = state_reg.driveSel;
        end
        STRAP_STATUS_REG_ADDR: begin
          state_next.rdata[1:0] = strapLatched;                // RULE7
          state_next.rdata[STRAP_LOADED_BIT] = state_reg.loaded;
        end
        default: begin
          state_next.rdata = REG_RESET;  // unmapped reads as zero
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regRdata         = state_reg.rdata;
  assign data_rate_select = state_reg.fcrBit0;
  assign strapsLoaded     = state_reg.loaded;
endmodule

// ---- rtl/mvs_pkg.sv ----
package mvs_pkg;
  // register map, index and byte address on the plain port
  localparam logic [11:0] MEDIA_ID_DRIVE_REG_ADDR = 12'h3F3;
  localparam logic [11:0] FUNC_CTRL_REG_ADDR      = 12'h3F4;
  localparam logic [11:0] DRIVE_SEL_REG_ADDR      = 12'h3F5;
  localparam logic [11:0] STRAP_STATUS_REG_ADDR   = 12'h3F6;
  // field positions
  localparam int MEDIA_VALID_BIT = 5;
  localparam int MEDIA_ID_LO_BIT = 6;
  localparam int DATA_RATE_SEL_BIT = 0;
  localparam int DRIVE_SEL_BIT = 0;
  localparam int STRAP_LOADED_BIT = 7;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] MEDIA_ID_RESET = 2'h0;

  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } mvs_req_type;

  // latched strap pair
  typedef struct packed {
    logic drive1;
    logic drive0;
  } mvs_strap_type;
endpackage

// ---- rtl/mvs_strap_sampler.sv ----
`timescale 1ns/100ps
// samples straps while reset is low, freezes them after release
module mvs_strap_sampler (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire mvs_pkg::mvs_strap_type strapPins,
  output logic                       sampleDone,
  output mvs_pkg::mvs_strap_type     strapLatched
);
  import mvs_pkg::*;

  typedef struct packed {
    mvs_strap_type sync1;   // first stage, read only by sync2
    mvs_strap_type sync2;   // second stage
    logic          done;    // frozen
    mvs_strap_type held;    // latched strap values
  } mvs_samp_state_type;

  mvs_samp_state_type state_reg;
  mvs_samp_state_type state_next;
  logic               resetSync1;   // synchronised reset level
  logic               resetSync2;

  // reset level synchroniser; async reset only loads constants
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resetSync1 <= 1'b0;
      resetSync2 <= 1'b0;
    end else begin
      resetSync1 <= 1'b1;
      resetSync2 <= resetSync1;
    end
  end

  // track straps while internal reset holds, freeze on release
  always_comb begin
    state_next       = state_reg;
    state_next.sync1 = strapPins;
    state_next.sync2 = state_reg.sync1;
    if (!resetSync2) begin
      state_next.held = state_reg.sync2;  // RULE1
      state_next.done = 1'b0;
    end else begin
      // no reload here: sync2 may already carry post-reset pin noise
      state_next.done = 1'b1;             // RULE7
    end
  end

  // no reset on purpose: the capture must keep running during reset
  // limitation: a reset that spans no clock edge leaves done stale
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign sampleDone   = state_reg.done;
  assign strapLatched = state_reg.held;
endmodule

// ---- testbench/mvs_strap_model.sv ----
`timescale 1ns/100ps
// strap resistors seen by the device pins
module mvs_strap_model (
  input  wire logic       reset_n,
  input  wire logic [1:0] fitHigh,
  input  wire logic [1:0] noise,
  output logic            pin0,
  output logic            pin1
);
  // pull-ups hold only in reset; afterwards the pins wander freely
  assign pin0 = reset_n ? noise[0] : fitHigh[0];
  assign pin1 = reset_n ? noise[1] : fitHigh[1];
endmodule

// ---- testbench/mvs_media_id_valid_strap_assertions.sv ----
`timescale 1ns/100ps
module mvs_media_id_valid_strap_assertions
  import mvs_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        media_valid_strap_drive0,
  input wire logic        media_valid_strap_drive1,
  input wire logic [11:0] regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdata,
  input wire logic        data_rate_select,
  input wire logic        strapsLoaded
);
  logic [1:0] capStrap; // pins as last seen in reset
  logic       selDrv;   // mirror of drive select
  // no async reset here: straps must be sampled while reset is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      capStrap <= {media_valid_strap_drive1, media_valid_strap_drive0};
      selDrv   <= 1'b0;
    end else if (regWr && regAddr == DRIVE_SEL_REG_ADDR) begin
      selDrv <= regWdata[DRIVE_SEL_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // live media read of drive d
  sequence rdDrv(d);
    regRd && regAddr == MEDIA_ID_DRIVE_REG_ADDR && strapsLoaded &&
      !data_rate_select && selDrv == d;
  endsequence
  AST_STATUS: assert property (regRd && strapsLoaded &&
    regAddr == STRAP_STATUS_REG_ADDR |=> regRdata[1:0] == capStrap)
    else $error("strap status wrong");
  AST_D0_LOW: assert property (rdDrv(1'b0) ##0 !capStrap[0]
    |=> !regRdata[MEDIA_VALID_BIT]) else $error("drive0 not valid");
  AST_D0_HIGH: assert property (rdDrv(1'b0) ##0 capStrap[0]
    |=> regRdata[MEDIA_VALID_BIT]) else $error("drive0 not invalid");
  AST_D1: assert property (rdDrv(1'b1)
    |=> regRdata[MEDIA_VALID_BIT] == capStrap[1]) else $error("drive1 flag");
  AST_RATE_LOAD: assert property ($rose(strapsLoaded)
    |-> data_rate_select == capStrap[0]) else $error("rate bit load");
  AST_VOID: assert property (regRd && data_rate_select &&
    regAddr == MEDIA_ID_DRIVE_REG_ADDR |=> regRdata[7:5] == 3'h1)
    else $error("void flag");
  AST_HOLD: assert property (strapsLoaded |=> strapsLoaded)
    else $error("loaded dropped");
endmodule
bind mvs_media_id_valid_strap mvs_media_id_valid_strap_assertions i_chk (
  .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
  .media_valid_strap_drive0(media_valid_strap_drive0),
  .media_valid_strap_drive1(media_valid_strap_drive1),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .data_rate_select(data_rate_select), .strapsLoaded(strapsLoaded));

// ---- testbench/mvs_media_id_valid_strap_tb.sv ----
`timescale 1ns/100ps
module mvs_media_id_valid_strap_tb;
  import mvs_pkg::*;
  logic        clk = 0, reset_n = 0, regWr = 0, regRd = 0;
  logic        p0, p1, dr, loaded;
  logic [1:0]  fit = 0, noise = 0, id0 = 0, id1 = 0;
  logic [11:0] regAddr = 0;
  logic [7:0]  regWdata = 0, regRdata, got;
  logic [3:0]  idAt = 0;
  int          errCount = 0, totalChecks = 0;
  int unsigned seed = 89;
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // reference image of the media id drive register
  function automatic logic [7:0] exp_media(int k, int d, int rate,
                                           logic [3:0] ids);
    if (rate != 0) return 8'h20;
    return {(d != 0) ? ids[3:2] : ids[1:0], 1'(k >> d), 5'h00};
  endfunction
  initial forever #2 clk = ~clk;
  // strap pins and media ids keep moving after reset
  always @(posedge clk) begin
    noise <= 2'(rnd());
    id0 <= 2'(rnd());
    id1 <= 2'(rnd());
  end
  mvs_strap_model i_strap (.reset_n(reset_n), .fitHigh(fit),
    .noise(noise), .pin0(p0), .pin1(p1));
  mvs_media_id_valid_strap i_dut (.clk(clk), .reset_n(reset_n),
    .media_valid_strap_drive0(p0), .media_valid_strap_drive1(p1),
    .mediaIdDrive0(id0), .mediaIdDrive1(id1), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .data_rate_select(dr), .strapsLoaded(loaded));
  task chk(string n, logic [7:0] e, logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [11:0] a, logic [7:0] d);
    @(posedge clk);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(logic [11:0] a);
    @(posedge clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk);
    idAt = {id1, id0};
    regRd <= 0;
    #1 got = regRdata;
  endtask
  task end_sim;
    if (errCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // every strap pairing, each behind a fresh reset
  initial begin
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      fit <= 2'(k);
      reset_n <= 0;
      repeat (20) @(posedge clk);
      reset_n <= 1;
      repeat (50) if (!loaded) @(posedge clk);
      chk("loaded", 8'h01, {7'h0, loaded});
      chk("rate", 8'(k & 1), {7'h0, dr});
      rd(STRAP_STATUS_REG_ADDR);
      chk("status", 8'h80 | 8'(k), got);
      for (int d = 0; d < 2; d++) begin
        wr(DRIVE_SEL_REG_ADDR, 8'(d));
        wr(FUNC_CTRL_REG_ADDR, 8'h00);
        rd(MEDIA_ID_DRIVE_REG_ADDR);
        chk("valid", exp_media(k, d, 0, idAt), got);
        wr(FUNC_CTRL_REG_ADDR, 8'h01);
        rd(MEDIA_ID_DRIVE_REG_ADDR);
        chk("void", exp_media(k, d, 1, idAt), got);
        chk("rate sw", 8'h01, {7'h0, dr});
        rd(FUNC_CTRL_REG_ADDR);
        chk("fctl", 8'h01, got);
        rd(DRIVE_SEL_REG_ADDR);
        chk("dsel", 8'(d), got);
      end
      rd(12'h000);
      chk("unmapped", 8'h00, got);
    end
    end_sim;
  end
  // hang guard well past the four reset rounds
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    end_sim;
  end
endmodule
